//--- logic/ttx_host_port.sv
// Host register port of the tone transceiver with burst timer and interrupt pin.
`timescale 1ns/1ps

module ttx_host_port
    import ttx_pkg::*;
#(
    parameter int BURST_TONE_CYCLES = BURST_TONE_CYC,
    parameter int BURST_PROG_CYCLES = BURST_PROG_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic soft_reset,
    input wire ttx_bus_t bus_req,
    output logic [3:0] rdata,
    input wire logic rx_valid_pin,
    input wire logic [3:0] rx_code_pin,
    input wire logic delayed_steer_pin,
    input wire logic progress_tone_pin,
    output logic [3:0] tx_code,
    output logic tx_active,
    output ttx_cfg_t cfg,
    output logic interrupt_progress_pin_out,
    output logic interrupt_progress_pin_oe
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Both stages of the pin synchroniser and the valid-edge history.
    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic rx_valid_s;
    logic [3:0] rx_code_s;
    logic steer_s;
    logic prog_s;
    logic rx_valid_last_q;

    // Two flops for every pin from the analogue receiver side.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sync1_q <= 7'h00;
            sync2_q <= 7'h00;
        end else if (clk_en) begin
            sync1_q <= {rx_valid_pin, rx_code_pin, delayed_steer_pin, progress_tone_pin};
            sync2_q <= sync1_q;
        end
    end
    // Only the second stage is read, so a metastable first stage never reaches logic.
    assign {rx_valid_s, rx_code_s, steer_s, prog_s} = sync2_q;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    // Host-visible registers, status flags and sequencer state.
    logic [3:0] ctrl_a_q, ctrl_a_d;
    logic [3:0] ctrl_b_q, ctrl_b_d;
    logic steer_q, steer_d;
    logic [3:0] tx_code_q, tx_code_d;
    logic [3:0] rx_code_q, rx_code_d;
    logic rx_flag_q, rx_flag_d;
    logic rx_irq_q, rx_irq_d;
    logic tx_ready_q, tx_ready_d;
    logic tx_irq_q, tx_irq_d;
    logic [3:0] rdata_q, rdata_d;
    ttx_burst_t burst_q, burst_d;
    logic [31:0] cnt_q, cnt_d;
    // Decoded strobes and helpers of the receive and burst paths.
    logic wr_data, rd_data, wr_ctrl, rd_stat;
    logic rx_new, tx_done;
    logic [31:0] burst_len;

    // Request decode from select line and direction.
    assign wr_data = bus_req.strobe && bus_req.sel == SEL_DATA && !bus_req.rd;
    assign rd_data = bus_req.strobe && bus_req.sel == SEL_DATA && bus_req.rd;
    assign wr_ctrl = bus_req.strobe && bus_req.sel == SEL_CTRL && !bus_req.rd;
    assign rd_stat = bus_req.strobe && bus_req.sel == SEL_CTRL && bus_req.rd;

    // Decoded configuration seen by the tone paths.
    always_comb begin
        cfg.tone_out = ctrl_a_q[CPA_TONE_OUT];
        cfg.prog_mode = ctrl_a_q[CPA_MODE];
        cfg.irq_en = ctrl_a_q[CPA_IRQ_EN];
        cfg.burst_n = ctrl_b_q[CSB_BURST_N];
        cfg.test = ctrl_b_q[CSB_TEST];
        cfg.single = ctrl_b_q[CSB_SINGLE];
        cfg.column = ctrl_b_q[CSB_COLUMN];
    end

    // A new code is captured on the rising edge of the valid pin, tone mode only.
    assign rx_new = rx_valid_s && !rx_valid_last_q && !cfg.prog_mode;
    // The burst length follows the mode at the moment a phase begins.
    assign burst_len = cfg.prog_mode ? 32'(BURST_PROG_CYCLES) : 32'(BURST_TONE_CYCLES);
    // The transmitter turns ready on the last cycle of the pause.
    assign tx_done = burst_q == TTX_PAUSE && cnt_q == 32'h0000_0001;

    // Next values of control, data and status state.
    always_comb begin
        ctrl_a_d = ctrl_a_q;
        ctrl_b_d = ctrl_b_q;
        steer_d = steer_q;
        tx_code_d = tx_code_q;
        rx_code_d = rx_code_q;
        rx_flag_d = rx_flag_q;
        rx_irq_d = rx_irq_q;
        tx_ready_d = tx_ready_q;
        tx_irq_d = tx_irq_q;
        rdata_d = rdata_q;
        // Control writes follow the steering bit left by the previous control write.
        if (wr_ctrl) begin
            if (steer_q) begin
                ctrl_b_d = bus_req.wdata;
                steer_d = 1'b0;
            end else begin
                ctrl_a_d = bus_req.wdata;
                steer_d = bus_req.wdata[CPA_STEER];
            end
        end
        // A new transmit code withdraws ready until a burst pause runs out or a software reset restores it.
        if (wr_data) begin
            tx_code_d = bus_req.wdata;
            tx_ready_d = 1'b0;
            tx_irq_d = 1'b0;
        end
        // A data read returns the held receive code; writes never reach it.
        if (rd_data) begin
            rdata_d = rx_code_q;
        end
        // A status read reports the flags and clears the receive flag and interrupts.
        if (rd_stat) begin
            rdata_d = 4'h0;
            rdata_d[STS_IRQ] = rx_irq_q || tx_irq_q;
            rdata_d[STS_TX_READY] = tx_ready_q;
            rdata_d[STS_RX_VALID] = rx_flag_q;
            rdata_d[STS_STEER_N] = !steer_s;
            rx_flag_d = 1'b0;
            rx_irq_d = 1'b0;
            tx_irq_d = 1'b0;
        end
        // Hardware events win over a coincident status-read clear.
        if (rx_new) begin
            rx_code_d = rx_code_s;
            rx_flag_d = 1'b1;
            rx_irq_d = 1'b1;
        end
        if (tx_done) begin
            tx_ready_d = 1'b1;
            tx_irq_d = 1'b1;
        end
        // Software reset comes last so that it overrides coincident events on control, flags and ready; codes and read data still load.
        if (soft_reset) begin
            ctrl_a_d = CTRL_RESET;
            ctrl_b_d = CTRL_RESET;
            steer_d = 1'b0;
            rx_flag_d = 1'b0;
            rx_irq_d = 1'b0;
            tx_irq_d = 1'b0;
            tx_ready_d = TX_READY_RESET;
        end
    end

    // Registers of the host-visible state; values held until rewritten.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_a_q <= CTRL_RESET;
            ctrl_b_q <= CTRL_RESET;
            steer_q <= 1'b0;
            tx_code_q <= CODE_RESET;
            rx_code_q <= CODE_RESET;
            rx_flag_q <= 1'b0;
            rx_irq_q <= 1'b0;
            tx_ready_q <= TX_READY_RESET;
            tx_irq_q <= 1'b0;
            rdata_q <= 4'h0;
            rx_valid_last_q <= 1'b0;
        end else if (clk_en) begin
            ctrl_a_q <= ctrl_a_d;
            ctrl_b_q <= ctrl_b_d;
            steer_q <= steer_d;
            tx_code_q <= tx_code_d;
            rx_code_q <= rx_code_d;
            rx_flag_q <= rx_flag_d;
            rx_irq_q <= rx_irq_d;
            tx_ready_q <= tx_ready_d;
            tx_irq_q <= tx_irq_d;
            rdata_q <= rdata_d;
            rx_valid_last_q <= rx_valid_s;
        end
    end

    // ------------------------------------------------------------------
    // Burst sequencer: burst, equal pause, then transmitter ready
    // ------------------------------------------------------------------
    always_comb begin
        burst_d = burst_q;
        cnt_d = cnt_q;
        // Each phase counts down from the burst length, so the pause equals the burst.
        case (burst_q)
            TTX_IDLE: begin
                if (wr_data && !cfg.burst_n) begin
                    burst_d = TTX_BURST;
                    cnt_d = burst_len;
                end
            end
            TTX_BURST: begin
                if (cnt_q <= 32'h0000_0001) begin
                    burst_d = TTX_PAUSE;
                    cnt_d = burst_len;
                end else begin
                    cnt_d = cnt_q - 32'h0000_0001;
                end
            end
            TTX_PAUSE: begin
                if (cnt_q <= 32'h0000_0001) begin
                    burst_d = TTX_IDLE;
                    cnt_d = 32'h0000_0000;
                end else begin
                    cnt_d = cnt_q - 32'h0000_0001;
                end
            end
            default: begin
                burst_d = TTX_IDLE;
                cnt_d = 32'h0000_0000;
            end
        endcase
        // Leaving burst mode or a software reset aborts a running burst.
        if (soft_reset || cfg.burst_n) begin
            burst_d = TTX_IDLE;
            cnt_d = 32'h0000_0000;
        end
    end

    // Sequencer registers.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            burst_q <= TTX_IDLE;
            cnt_q <= 32'h0000_0000;
        end else if (clk_en) begin
            burst_q <= burst_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs and the open-drain pin
    // ------------------------------------------------------------------
    // Registered pin level, so the pin never glitches on decode.
    logic pin_low_q, pin_low_d;

    // Pin low means interrupt, steering in test mode or, in progress mode with interrupts enabled, the tone wave low.
    always_comb begin
        pin_low_d = 1'b0;
        if (cfg.prog_mode) begin
            pin_low_d = cfg.irq_en && !prog_s;
        end else if (cfg.test) begin
            // Test mode shows the steering inverted: low while a tone is valid.
            pin_low_d = steer_s;
        end else if (cfg.irq_en) begin
            // Transmit-ready counts only while burst mode is selected.
            pin_low_d = rx_irq_q || (tx_irq_q && !cfg.burst_n);
        end
    end

    // Pin driver register.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin_low_q <= 1'b0;
        end else if (clk_en) begin
            pin_low_q <= pin_low_d;
        end
    end

    // Open drain: the pin is only ever driven low, through its enable.
    assign interrupt_progress_pin_out = 1'b0;
    assign interrupt_progress_pin_oe = !pin_low_q; // Low enable means pulling low.
    // Data outputs come straight from their registers.
    assign rdata = rdata_q;
    assign tx_code = tx_code_q;
    // Tone output gated by enable and, in burst mode, by the burst phase.
    assign tx_active = cfg.tone_out && (cfg.burst_n || burst_q == TTX_BURST);

endmodule : ttx_host_port

//--- logic/ttx_pkg.sv
// Package with register map, field positions, timing and carrier types of the tone host port.
package ttx_pkg;

    // ------------------------------------------------------------------
    // Register selection and field positions
    // ------------------------------------------------------------------
    localparam logic SEL_DATA = 1'h0;
    localparam logic SEL_CTRL = 1'h1;
    localparam int CPA_TONE_OUT = 0;
    localparam int CPA_MODE = 1;
    localparam int CPA_IRQ_EN = 2;
    localparam int CPA_STEER = 3;
    localparam int CSB_BURST_N = 0;
    localparam int CSB_TEST = 1;
    localparam int CSB_SINGLE = 2;
    localparam int CSB_COLUMN = 3;
    localparam int STS_IRQ = 0;
    localparam int STS_TX_READY = 1;
    localparam int STS_RX_VALID = 2;
    localparam int STS_STEER_N = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [3:0] CODE_RESET = 4'h0;
    localparam logic TX_READY_RESET = 1'h1;

    // ------------------------------------------------------------------
    // Burst timing: 51 ms in tone mode, doubled to 102 ms in progress mode
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int BURST_TONE_MS = 51;
    localparam int BURST_TONE_CYC = BURST_TONE_MS * 1000 * CLK_MHZ;
    localparam int BURST_PROG_MS = 102;
    localparam int BURST_PROG_CYC = BURST_PROG_MS * 1000 * CLK_MHZ;

    // Burst sequencer states.
    typedef enum logic [1:0] {
        TTX_IDLE,
        TTX_BURST,
        TTX_PAUSE
    } ttx_burst_t;

    // Host bus request bundle.
    typedef struct packed {
        logic strobe;
        logic sel;
        logic rd;
        logic [3:0] wdata;
    } ttx_bus_t;

    // Configuration decoded from both control registers.
    typedef struct packed {
        logic tone_out;
        logic prog_mode;
        logic irq_en;
        logic burst_n;
        logic test;
        logic single;
        logic column;
    } ttx_cfg_t;

endpackage : ttx_pkg

//--- tb/tb_top.sv
// Self-checking bench for the tone host port.
`timescale 1ns/1ps
module tb_top;
    import ttx_pkg::*;
    localparam int TONE_CYC = 10;
    localparam int PROG_CYC = 20;
    logic clk_sys;
    logic reset;
    logic clk_en;
    logic soft_reset;
    ttx_bus_t bus_req;
    logic [3:0] rdata;
    logic rx_valid_pin;
    logic [3:0] rx_code_pin;
    logic delayed_steer_pin;
    logic progress_tone_pin;
    logic [3:0] tx_code;
    logic tx_active;
    ttx_cfg_t cfg;
    logic interrupt_progress_pin_out;
    logic interrupt_progress_pin_oe;
    int miscompares;
    int checks;
    int n;
    ttx_host_port #(.BURST_TONE_CYCLES(TONE_CYC), .BURST_PROG_CYCLES(PROG_CYC)) uut (
        .clk_sys, .reset, .clk_en, .soft_reset, .bus_req, .rdata, .rx_valid_pin,
        .rx_code_pin, .delayed_steer_pin, .progress_tone_pin, .tx_code, .tx_active,
        .cfg, .interrupt_progress_pin_out, .interrupt_progress_pin_oe);
    ttx_tone_src src (.clk_sys, .rx_valid_pin, .rx_code_pin, .delayed_steer_pin,
        .progress_tone_pin);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic chk(input logic [6:0] g, input logic [6:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // One access, request held for exactly one taking edge.
    task automatic acc(input logic s, input logic r, input logic [3:0] w);
        @(posedge clk_sys);
        bus_req <= '{1'b1, s, r, w};
        @(posedge clk_sys);
        bus_req.strobe <= 1'b0;
    endtask : acc
    task automatic rdc(input logic s, input logic [3:0] m, input logic [3:0] e);
        acc(s, 1'b1, 4'h0);
        @(posedge clk_sys);
        #1 chk(7'(rdata & m), 7'(e));
    endtask : rdc
    // Writes a code and counts the cycles that the tone gate stays open.
    task automatic burst(input logic [3:0] c, input int len);
        acc(SEL_DATA, 1'b0, c);
        #1 chk(7'(tx_code), 7'(c));
        n = 0;
        while (tx_active === 1'b1 && n < 100) begin
            @(posedge clk_sys);
            #1 n++;
        end
        if (n >= 100) begin
            miscompares++;
            close_out();
        end
        chk(7'(n), 7'(len));
    endtask : burst
    initial begin
        reset = 1'b1;
        clk_en = 1'b1;
        soft_reset = 1'b0;
        bus_req = '0;
        miscompares = 0;
        checks = 0;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        soft_reset <= 1'b1;
        @(posedge clk_sys);
        soft_reset <= 1'b0;
        #1 chk(cfg, 7'h00);
        acc(SEL_CTRL, 1'b0, 4'h9);
        #1 chk(cfg, 7'h40);
        acc(SEL_CTRL, 1'b0, 4'hE);
        #1 chk(cfg, 7'h47);
        acc(SEL_CTRL, 1'b0, 4'h4);
        #1 chk(cfg, 7'h17);
        fork
            src.tone(4'h7);
            begin
                repeat (6) @(posedge clk_sys);
                #1 chk(7'(interrupt_progress_pin_oe), 7'h0);
            end
        join
        rdc(SEL_DATA, 4'hF, 4'h7);
        rdc(SEL_CTRL, 4'h4, 4'h4);
        rdc(SEL_CTRL, 4'h4, 4'h0);
        $display("routing and test pin done");
        acc(SEL_CTRL, 1'b0, 4'h8);
        @(posedge clk_sys);
        soft_reset <= 1'b1;
        @(posedge clk_sys);
        soft_reset <= 1'b0;
        #1 chk(cfg, 7'h00);
        acc(SEL_CTRL, 1'b0, 4'hC);
        #1 chk(cfg, 7'h10);
        acc(SEL_CTRL, 1'b0, 4'h0);
        src.tone(4'h5);
        #1 chk(7'(interrupt_progress_pin_oe), 7'h0);
        rdc(SEL_DATA, 4'hF, 4'h5);
        rdc(SEL_CTRL, 4'h4, 4'h4);
        repeat (3) @(posedge clk_sys);
        #1 chk(7'(interrupt_progress_pin_oe), 7'h1);
        $display("receive done");
        acc(SEL_CTRL, 1'b0, 4'h6);
        src.tone(4'h9);
        rdc(SEL_DATA, 4'hF, 4'h5);
        src.wave(1'b0, 8);
        #1 chk(7'(interrupt_progress_pin_oe), 7'h0);
        src.wave(1'b1, 8);
        #1 chk(7'(interrupt_progress_pin_oe), 7'h1);
        $display("progress mode done");
        acc(SEL_CTRL, 1'b0, 4'hD);
        acc(SEL_CTRL, 1'b0, 4'h0);
        burst(4'hA, TONE_CYC);
        repeat (TONE_CYC + 2) @(posedge clk_sys);
        #1 chk(7'(interrupt_progress_pin_oe), 7'h0);
        rdc(SEL_CTRL, 4'h2, 4'h2);
        rdc(SEL_DATA, 4'hF, 4'h5);
        acc(SEL_CTRL, 1'b0, 4'hF);
        acc(SEL_CTRL, 1'b0, 4'h0);
        burst(4'h3, PROG_CYC);
        $display("burst done");
        @(posedge clk_sys);
        clk_en <= 1'b0;
        acc(SEL_CTRL, 1'b0, 4'h0);
        #1 chk(cfg, 7'h70);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        acc(SEL_CTRL, 1'b0, 4'h0);
        #1 chk(cfg, 7'h00);
        $display("clock enable done");
        close_out();
    end
endmodule : tb_top

//--- tb/ttx_port_monitor.sv
// Checker of the tone host port outputs.
`timescale 1ns/1ps
module ttx_port_monitor
    import ttx_pkg::*;
#(
    parameter int BURST_TONE_CYCLES = 10,
    parameter int BURST_PROG_CYCLES = 20
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic soft_reset,
    input wire ttx_bus_t bus_req,
    input wire logic [3:0] rdata,
    input wire logic rx_valid_pin,
    input wire logic [3:0] rx_code_pin,
    input wire logic delayed_steer_pin,
    input wire logic progress_tone_pin,
    input wire logic [3:0] tx_code,
    input wire logic tx_active,
    input wire ttx_cfg_t cfg,
    input wire logic interrupt_progress_pin_out,
    input wire logic interrupt_progress_pin_oe
);
    logic cw;
    logic steer_d;
    logic steer_q;
    // Tracks which control register the next control write reaches.
    assign cw = clk_en && bus_req.strobe && bus_req.sel && !bus_req.rd;
    always_comb begin
        steer_d = steer_q;
        if (clk_en && soft_reset) steer_d = 1'b0;
        else if (cw) steer_d = !steer_q && bus_req.wdata[CPA_STEER];
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) steer_q <= 1'b0;
        else steer_q <= steer_d;
    end
    logic [31:0] run_q;
    logic [31:0] run_d;
    // Counts the enabled cycles of an open tone gate in burst mode.
    always_comb begin
        run_d = 32'h0;
        if (tx_active && !cfg.burst_n) run_d = clk_en ? run_q + 32'h1 : run_q;
    end
    // Register of the gate counter.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) run_q <= 32'h0;
        else run_q <= run_d;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_wave(bit v);
        clk_en && cfg.prog_mode && cfg.irq_en && progress_tone_pin == v;
    endsequence
    sequence s_idle;
        clk_en && !cfg.prog_mode && !cfg.irq_en && !cfg.test;
    endsequence
    property p_drive; interrupt_progress_pin_out == 1'b0; endproperty
    a_drive: assert property (p_drive) else $error("pin driven high");
    property p_tx_wr;
        clk_en && bus_req.strobe && !bus_req.sel && !bus_req.rd && !soft_reset
        |=> tx_code == $past(bus_req.wdata);
    endproperty
    a_tx_wr: assert property (p_tx_wr) else $error("tx code not loaded");
    property p_ctl_a;
        cw && !soft_reset && !steer_q
        |=> {cfg.irq_en, cfg.prog_mode, cfg.tone_out} == $past(bus_req.wdata[2:0]);
    endproperty
    a_ctl_a: assert property (p_ctl_a) else $error("primary write lost");
    property p_ctl_b;
        cw && !soft_reset && steer_q
        |=> {cfg.column, cfg.single, cfg.test, cfg.burst_n} == $past(bus_req.wdata);
    endproperty
    a_ctl_b: assert property (p_ctl_b) else $error("secondary write lost");
    property p_hold; !(clk_en && (cw || soft_reset)) |=> $stable(cfg); endproperty
    a_hold: assert property (p_hold) else $error("control changed alone");
    property p_soft; clk_en && soft_reset |=> cfg == '0; endproperty
    a_soft: assert property (p_soft) else $error("soft reset left control");
    property p_rd_hold;
        !(clk_en && bus_req.strobe && bus_req.rd) && !soft_reset |=> $stable(rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_gate; tx_active |-> cfg.tone_out; endproperty
    a_gate: assert property (p_gate) else $error("tone without enable");
    property p_wave;
        s_wave(1'b0)[*6] |-> !interrupt_progress_pin_oe;
    endproperty
    a_wave: assert property (p_wave) else $error("wave low not shown");
    property p_quiet; s_idle[*2] |-> interrupt_progress_pin_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("pin low while off");
    property p_burst_len;
        tx_active && !cfg.burst_n
        |-> run_q < (cfg.prog_mode ? 32'(BURST_PROG_CYCLES) : 32'(BURST_TONE_CYCLES));
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("tone burst too long");
endmodule : ttx_port_monitor
bind ttx_host_port ttx_port_monitor #(.BURST_TONE_CYCLES(BURST_TONE_CYCLES),
    .BURST_PROG_CYCLES(BURST_PROG_CYCLES)) mon (.clk_sys, .reset, .clk_en, .soft_reset,
    .bus_req, .rdata, .rx_valid_pin, .rx_code_pin, .delayed_steer_pin, .progress_tone_pin,
    .tx_code, .tx_active, .cfg, .interrupt_progress_pin_out, .interrupt_progress_pin_oe);

//--- tb/ttx_tone_src.sv
// Model of the receiver front end that feeds the host port.
`timescale 1ns/1ps
module ttx_tone_src (
    input wire logic clk_sys,
    output logic rx_valid_pin,
    output logic [3:0] rx_code_pin,
    output logic delayed_steer_pin,
    output logic progress_tone_pin
);
    // Idle levels at time zero.
    initial begin
        rx_valid_pin = 1'b0;
        rx_code_pin = 4'h0;
        delayed_steer_pin = 1'b0;
        progress_tone_pin = 1'b1;
    end
    // One validated tone pair; code lines show the inverse once released.
    task automatic tone(input logic [3:0] c);
        @(posedge clk_sys);
        rx_code_pin <= c;
        delayed_steer_pin <= 1'b1;
        @(posedge clk_sys);
        rx_valid_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        delayed_steer_pin <= 1'b0;
        rx_valid_pin <= 1'b0;
        rx_code_pin <= ~c;
    endtask : tone
    // Holds the detected progress wave at one level for n cycles.
    task automatic wave(input logic v, input int n);
        @(posedge clk_sys);
        progress_tone_pin <= v;
        repeat (n) @(posedge clk_sys);
    endtask : wave
endmodule : ttx_tone_src
